//--- pkg/pfe_pkg.sv
// pfe_pkg: register map, field positions and reset values of the fault, event and soft reset block.
// assumes a byte-wide register port fed by the serial interface logic.
`default_nettype none
package pfe_pkg;
    localparam logic [7:0] ADDR_FAULT_LATCH = 8'h17;
    localparam logic [7:0] ADDR_SOFT_RESET  = 8'h18;
    localparam logic [7:0] ADDR_TOP_EVENTS  = 8'h19;
    localparam logic [7:0] ADDR_LIVE_STATUS = 8'h1D;

    localparam logic [1:0] FAULT_RESET      = 2'h0;
    localparam logic [7:0] TOP_RESET        = 8'h00;
    localparam logic [7:0] READ_ZERO        = 8'h00;

    localparam int SOFT_RESET_BIT = 0;
    localparam int TOP_PG_BIT     = 7;
    localparam int TOP_CONV_BIT   = 5;
    localparam int TOP_CLK_BIT    = 4;
    localparam int TOP_TSD_BIT    = 3;
    localparam int TOP_WARN_BIT   = 2;
    localparam int TOP_OVP_BIT    = 1;
    localparam int TOP_MEAS_BIT   = 0;

    // bits that host write-one clears; bit 5 follows the converter events and bit 6 is reserved
    localparam logic [7:0] TOP_W1C_MASK = 8'h9F;
endpackage : pfe_pkg
`default_nettype wire

//--- verilog/pfe_event_reset.sv
// pfe_event_reset: power-good fault latches, top-level event flags and self-clearing soft reset.
// assumes all inputs synchronous to clock_in and a register port driven by the serial interface.
//
// Summary of operation
// [R1] a monitored converter that drops power-good sets its fault latch bit
// [R2] host write-one clears a fault bit only while that converter is valid
// [R3] fault bit stays zero until its converter makes power-good inactive
// [R4] writing one to soft reset returns all registers to defaults
// [R5] soft reset also pulses configuration reload and serial interface reset
// [R6] soft reset bit clears itself after the reset is taken
// [R7] top converter event bit is read-only, set while any converter event pends
// [R8] top converter event bit clears once converter events are all zero
// [R9] external clock appearing or disappearing latches bit 4
// [R10] thermal shutdown latches bit 3, disables regulators, drives outputs low
// [R11] regulators cannot be enabled while the shutdown flag is set
// [R12] thermal warning latches bit 2; live warning shown in status
// [R13] input overvoltage latches bit 1, disables regulators, outputs low, live status
// [R14] latched top flags clear only on host write-one
// [R15] gating select one: power-good follows latches, else live voltages
// [R16] a converter counts for power-good only when its monitor enable is one
// [R17] power-good going active to inactive latches bit 7
// [R18] new current measurement result latches bit 0
`timescale 1ns/1ps
`default_nettype none
module pfe_event_reset
    import pfe_pkg::*;
(
    // clock and reset
    input  wire logic       clock_in,
    input  wire logic       rst_n_in,
    // register port from the serial interface
    input  wire logic [7:0] reg_addr_in,
    input  wire logic       reg_wr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_rd_in,
    output logic      [7:0] reg_rdata_out,
    // power-good configuration
    input  wire logic       power_ok_gating_select_in,
    input  wire logic       conv0_monitor_enable_in,
    input  wire logic       conv1_monitor_enable_in,
    // converter monitors
    input  wire logic       conv0_valid_in,
    input  wire logic       conv1_valid_in,
    input  wire logic [7:0] conv_event_reg_in,
    // device events
    input  wire logic       ext_clock_present_in,
    input  wire logic       thermal_shutdown_live_in,
    input  wire logic       thermal_warning_live_in,
    input  wire logic       input_overvoltage_live_in,
    input  wire logic       current_meas_ready_in,
    // regulator and general output requests
    input  wire logic       conv0_enable_req_in,
    input  wire logic       conv1_enable_req_in,
    input  wire logic       general_output_a_req_in,
    input  wire logic       general_output_b_req_in,
    // outputs
    output logic            power_ok_output_out,
    output logic            conv0_enable_out,
    output logic            conv1_enable_out,
    output logic            general_output_a_out,
    output logic            general_output_b_out,
    output logic            otp_reload_out,
    output logic            serial_reset_out
);
    logic [1:0] fault_q;
    logic [7:0] top_q;
    logic       soft_reset_q;
    logic       pg_q;
    logic [1:0] en_q;
    logic [1:0] en_prev_q;
    logic [1:0] gpo_q;
    logic       clk_prev_q;
    logic       tsd_prev_q;
    logic       warn_prev_q;
    logic       ovp_prev_q;
    logic [7:0] rdata_q;

    wire        clear_all   = !rst_n_in || soft_reset_q;
    wire        wr_fault    = reg_wr_in && (reg_addr_in == ADDR_FAULT_LATCH);
    wire        wr_top      = reg_wr_in && (reg_addr_in == ADDR_TOP_EVENTS);
    wire        soft_cmd    = reg_wr_in && (reg_addr_in == ADDR_SOFT_RESET) && reg_wdata_in[SOFT_RESET_BIT];

    wire [1:0]  mon_en      = {conv1_monitor_enable_in, conv0_monitor_enable_in};
    wire [1:0]  conv_valid  = {conv1_valid_in, conv0_valid_in};
    wire [1:0]  fault_set   = mon_en & ~conv_valid;                             // R1 R16
    wire [1:0]  fault_clr   = {2{wr_fault}} & reg_wdata_in[1:0] & conv_valid;   // R2
    wire [1:0]  fault_d     = (fault_q & ~fault_clr) | fault_set;               // R3
    wire        pg_live     = ~|fault_set;                                      // R16
    wire        pg_d        = power_ok_gating_select_in ? ~|fault_d : pg_live;  // R15

    wire        pg_fall     = pg_q & ~pg_d;                                     // R17
    wire        clk_change  = ext_clock_present_in ^ clk_prev_q;                // R9
    wire        tsd_rise    = thermal_shutdown_live_in & ~tsd_prev_q;
    wire        warn_rise   = thermal_warning_live_in & ~warn_prev_q;           // R12
    wire        ovp_rise    = input_overvoltage_live_in & ~ovp_prev_q;
    wire        conv_pend   = |conv_event_reg_in;                               // R7 R8

    wire [7:0]  top_set     = (8'(pg_fall) << TOP_PG_BIT) | (8'(clk_change) << TOP_CLK_BIT)
                            | (8'(tsd_rise) << TOP_TSD_BIT) | (8'(warn_rise) << TOP_WARN_BIT)
                            | (8'(ovp_rise) << TOP_OVP_BIT) | (8'(current_meas_ready_in) << TOP_MEAS_BIT);
    wire [7:0]  top_clr     = wr_top ? (reg_wdata_in & TOP_W1C_MASK) : READ_ZERO;
    // a flag raised in the same cycle as its clear survives
    wire [7:0]  top_d       = (top_q & ~top_clr) | top_set;                     // R14 R18
    wire [7:0]  top_word    = top_q | (8'(conv_pend) << TOP_CONV_BIT);          // R7

    wire        shut_evt    = tsd_rise | ovp_rise;                              // R10 R13
    wire        tsd_flag    = top_q[TOP_TSD_BIT];
    wire [1:0]  en_req      = {conv1_enable_req_in, conv0_enable_req_in};
    // enabling needs a fresh request edge, so a shutdown is not undone by a request left high
    wire [1:0]  en_d        = en_req & ~{2{shut_evt}} & (en_q | (~en_prev_q & ~{2{tsd_flag}})); // R11
    wire        gpo_block   = top_d[TOP_TSD_BIT] | top_d[TOP_OVP_BIT];          // R10 R13
    wire [1:0]  gpo_d       = {general_output_b_req_in, general_output_a_req_in} & ~{2{gpo_block}};

    wire [7:0]  stat_word   = {pg_q, 2'h0, ~ext_clock_present_in, thermal_shutdown_live_in,
                               thermal_warning_live_in, input_overvoltage_live_in, 1'b0}; // R12 R13
    wire [7:0]  rd_word     = (reg_addr_in == ADDR_FAULT_LATCH) ? {6'h00, fault_q} :
                              (reg_addr_in == ADDR_SOFT_RESET)  ? {7'h00, soft_reset_q} :
                              (reg_addr_in == ADDR_TOP_EVENTS)  ? top_word :
                              (reg_addr_in == ADDR_LIVE_STATUS) ? stat_word : READ_ZERO;

    // soft reset command holds for exactly one cycle, then every register except the edge history reloads
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            soft_reset_q <= 1'b0;
        end else begin
            soft_reset_q <= soft_cmd && !soft_reset_q;                          // R6
        end
    end

    always_ff @(posedge clock_in) begin
        if (clear_all) begin                                                    // R4
            fault_q   <= FAULT_RESET;
            top_q     <= TOP_RESET;
            pg_q      <= 1'b0;
            en_q      <= 2'h0;
            en_prev_q <= 2'h0;
            gpo_q     <= 2'h0;
            rdata_q   <= READ_ZERO;
        end else begin
            fault_q   <= fault_d;
            top_q     <= top_d;
            pg_q      <= pg_d;
            en_q      <= en_d;
            en_prev_q <= en_req;
            gpo_q     <= gpo_d;
            if (reg_rd_in) begin
                rdata_q <= rd_word;
            end
        end
    end

    // edge history is kept across soft reset so a steady clock does not look like a change
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            // loading the live level avoids a false clock change right after reset
            clk_prev_q  <= ext_clock_present_in;
            tsd_prev_q  <= 1'b0;
            warn_prev_q <= 1'b0;
            ovp_prev_q  <= 1'b0;
        end else begin
            clk_prev_q  <= ext_clock_present_in;
            tsd_prev_q  <= thermal_shutdown_live_in;
            warn_prev_q <= thermal_warning_live_in;
            ovp_prev_q  <= input_overvoltage_live_in;
        end
    end

    assign reg_rdata_out        = rdata_q;
    assign power_ok_output_out  = pg_q;
    assign conv0_enable_out     = en_q[0];
    assign conv1_enable_out     = en_q[1];
    assign general_output_a_out = gpo_q[0];
    assign general_output_b_out = gpo_q[1];
    assign otp_reload_out       = soft_reset_q;                                 // R5
    assign serial_reset_out     = soft_reset_q;                                 // R5

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);

    sequence soft_cmd_s;
        soft_cmd && !soft_reset_q;
    endsequence
    sequence regs_default_s;
        fault_q == FAULT_RESET && top_q == TOP_RESET && !conv0_enable_out && !conv1_enable_out;
    endsequence

    fault_set_a: assert property (conv1_monitor_enable_in && !conv1_valid_in && !soft_reset_q |=> fault_q[1]) // R1
        else $error("fault latch 1 not set");
    fault_keep_a: assert property (fault_q[0] && !conv0_valid_in && !soft_reset_q |=> fault_q[0]) // R2
        else $error("fault latch 0 cleared while converter invalid");
    fault_zero_a: assert property (!fault_q[0] && !(conv0_monitor_enable_in && !conv0_valid_in)
        |=> !fault_q[0]) // R3
        else $error("fault latch 0 set without cause");
    soft_reset_a: assert property (soft_cmd_s |=> soft_reset_q ##1 regs_default_s) // R4
        else $error("soft reset did not restore defaults");
    reload_pulse_a: assert property (soft_cmd_s |=> otp_reload_out && serial_reset_out) // R5
        else $error("reload and serial reset not pulsed");
    self_clear_a: assert property (soft_reset_q |=> !soft_reset_q) // R6
        else $error("soft reset bit did not clear");
    conv_event_a: assert property (reg_rd_in && !soft_reset_q && reg_addr_in == ADDR_TOP_EVENTS
        |=> reg_rdata_out[TOP_CONV_BIT] == $past(conv_pend)) // R7
        else $error("converter event bit wrong");
    shutdown_a: assert property (tsd_rise && !soft_reset_q
        |=> top_q[TOP_TSD_BIT] && !conv0_enable_out && !general_output_a_out && !general_output_b_out) // R10
        else $error("shutdown actions missing");
    tsd_block_a: assert property (tsd_flag && !en_q[1] |=> !en_q[1]) // R11
        else $error("regulator enabled during shutdown");
    ovp_off_a: assert property (ovp_rise && !soft_reset_q |=> top_q[TOP_OVP_BIT] && en_q == 2'h0) // R13
        else $error("overvoltage actions missing");
    w1c_zero_a: assert property (top_q[TOP_WARN_BIT] && !soft_reset_q
        && !(wr_top && reg_wdata_in[TOP_WARN_BIT]) |=> top_q[TOP_WARN_BIT]) // R14
        else $error("warning flag lost without write-one");
    pg_gated_a: assert property (power_ok_gating_select_in && |fault_d && !soft_reset_q
        |=> !power_ok_output_out) // R15
        else $error("power ok active with fault latched");
    pg_loss_a: assert property (pg_fall && !soft_reset_q |=> top_q[TOP_PG_BIT]) // R17
        else $error("power ok loss not latched");

    sequence outputs_low_s;
        !general_output_a_out && !general_output_b_out && !power_ok_output_out;
    endsequence

    // fault latches of both converters
    fault_set0_a: assert property (conv0_monitor_enable_in && !conv0_valid_in && !soft_reset_q
        |=> fault_q[0]) // R1
        else $error("fault latch 0 not set");
    fault_keep1_a: assert property (fault_q[1] && !conv1_valid_in && !soft_reset_q
        |=> fault_q[1]) // R2
        else $error("fault latch 1 cleared while converter invalid");
    fault_clear1_a: assert property (wr_fault && reg_wdata_in[1] && conv1_valid_in && !soft_reset_q
        |=> !fault_q[1]) // R2
        else $error("fault latch 1 not cleared");
    fault_zero1_a: assert property (!fault_q[1] && !(conv1_monitor_enable_in && !conv1_valid_in)
        |=> !fault_q[1]) // R3
        else $error("fault latch 1 set without cause");

    // soft reset steps
    clear_defaults_a: assert property (soft_reset_q
        |=> regs_default_s ##0 outputs_low_s) // R4
        else $error("outputs not low after soft reset");
    rdata_clear_a: assert property (soft_reset_q
        |=> reg_rdata_out == READ_ZERO) // R4
        else $error("read data not cleared by soft reset");
    serial_pulse_a: assert property (soft_cmd_s
        |=> serial_reset_out ##1 !serial_reset_out) // R5
        else $error("serial reset pulse wrong length");
    soft_read_a: assert property (reg_rd_in && reg_addr_in == ADDR_SOFT_RESET && !soft_reset_q
        |=> reg_rdata_out == READ_ZERO) // R6
        else $error("soft reset bit reads one when idle");

    // top-level flags
    top_read_only_a: assert property ((top_q & ~TOP_W1C_MASK) == READ_ZERO
        ) // R7
        else $error("read-only top bit latched");
    conv_clear_a: assert property (reg_rd_in && reg_addr_in == ADDR_TOP_EVENTS && !soft_reset_q
        && conv_event_reg_in == READ_ZERO |=> !reg_rdata_out[TOP_CONV_BIT]) // R8
        else $error("converter event bit stuck");
    clk_change_a: assert property (clk_change && !soft_reset_q
        |=> top_q[TOP_CLK_BIT]) // R9
        else $error("clock change not latched");
    clk_steady_a: assert property (!top_q[TOP_CLK_BIT] && !clk_change
        |=> !top_q[TOP_CLK_BIT]) // R9
        else $error("clock flag set without change");
    warn_latch_a: assert property (warn_rise && !soft_reset_q
        |=> top_q[TOP_WARN_BIT]) // R12
        else $error("warning not latched");
    warn_status_a: assert property (reg_rd_in && reg_addr_in == ADDR_LIVE_STATUS && !soft_reset_q
        |=> reg_rdata_out[TOP_WARN_BIT] == $past(thermal_warning_live_in)) // R12
        else $error("live warning status wrong");
    ovp_status_a: assert property (reg_rd_in && reg_addr_in == ADDR_LIVE_STATUS && !soft_reset_q
        |=> reg_rdata_out[TOP_OVP_BIT] == $past(input_overvoltage_live_in)) // R13
        else $error("live overvoltage status wrong");

    // protective actions
    shutdown_conv1_a: assert property (tsd_rise && !soft_reset_q
        |=> !conv1_enable_out) // R10
        else $error("regulator 1 kept on at shutdown");
    tsd_block0_a: assert property (tsd_flag && !en_q[0]
        |=> !en_q[0]) // R11
        else $error("regulator 0 enabled during shutdown");
    ovp_gpo_a: assert property (ovp_rise && !soft_reset_q
        |=> !general_output_a_out && !general_output_b_out) // R13
        else $error("general outputs high at overvoltage");

    // write-one clearing and flag latching
    w1c_keep_clk_a: assert property (top_q[TOP_CLK_BIT] && !soft_reset_q
        && !(wr_top && reg_wdata_in[TOP_CLK_BIT]) |=> top_q[TOP_CLK_BIT]) // R14
        else $error("clock flag lost without write-one");
    w1c_clear_a: assert property (wr_top && reg_wdata_in[TOP_MEAS_BIT] && !current_meas_ready_in
        |=> !top_q[TOP_MEAS_BIT]) // R14
        else $error("measurement flag not cleared");
    meas_latch_a: assert property (current_meas_ready_in && !soft_reset_q
        |=> top_q[TOP_MEAS_BIT]) // R18
        else $error("measurement flag not set");
    pg_loss_keep_a: assert property (top_q[TOP_PG_BIT] && !soft_reset_q
        && !(wr_top && reg_wdata_in[TOP_PG_BIT]) |=> top_q[TOP_PG_BIT]) // R17
        else $error("power ok loss flag lost");

    // power ok in live mode
    pg_live_a: assert property (!power_ok_gating_select_in && conv0_monitor_enable_in
        && !conv0_valid_in && !soft_reset_q |=> !power_ok_output_out) // R15
        else $error("power ok active with converter invalid");
    pg_unmon_a: assert property (!power_ok_gating_select_in && !conv0_monitor_enable_in
        && !conv1_monitor_enable_in && !soft_reset_q |=> power_ok_output_out) // R16
        else $error("unmonitored converter dropped power ok");
endmodule // pfe_event_reset
`default_nettype wire

//--- tb/pfe_host_model.sv
// pfe_host_model: host side of the register port, one byte per strobe.
// assumes the serial framing is done elsewhere; strobes move on falling edges.
`timescale 1ns/1ps
`default_nettype none
module pfe_host_model (
    // clock and read data
    input  wire logic       clock_in,
    input  wire logic [7:0] rdata_in,
    // register port
    output logic      [7:0] addr_out,
    output logic            wr_out,
    output logic      [7:0] wdata_out,
    output logic            rd_out
);
    initial begin
        addr_out  = 8'h00;
        wdata_out = 8'h00;
        {wr_out, rd_out} = 2'h0;
    end
    // released data is inverted so a stale byte is never mistaken for a write
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock_in);
        addr_out  = a;
        wdata_out = d;
        wr_out    = 1'b1;
        @(negedge clock_in);
        wr_out    = 1'b0;
        wdata_out = ~d;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(negedge clock_in);
        addr_out = a;
        rd_out   = 1'b1;
        @(negedge clock_in);
        rd_out   = 1'b0;
        d        = rdata_in;
    endtask
endmodule // pfe_host_model
`default_nettype wire

//--- tb/pfe_event_reset_tb.sv
// pfe_event_reset_tb: self-checking bench for the fault, event and soft reset block.
// assumes the host model drives the register port and this bench drives the monitors.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin err_total++; $display("[ERR] t=%0t got=%h exp=%h", $time, a, e); end end
module pfe_event_reset_tb;
    import pfe_pkg::*;
    typedef struct packed {logic [4:0] stim; logic [7:0] flags;} pfe_row_t;
    logic       clock_in, rst_n_in, reg_wr, reg_rd, gate_sel, mon0, mon1, val0, val1;
    logic       ext_clk, tsd, warn, ovp, meas, en0, en1, ga, gb, pok, cen0, cen1, goa, gob, otp, srst;
    logic [7:0] reg_addr, reg_wdata, rdata, conv_evt, rd_val;
    int         err_total, tests_run;
    // stim is {ext clock, warning, overvoltage, measurement, converter event}
    pfe_row_t   rows [5] = '{'{5'h10, 8'h10}, '{5'h08, 8'h04}, '{5'h04, 8'h02}, '{5'h02, 8'h01}, '{5'h01, 8'h20}};

    pfe_host_model host_u (.clock_in(clock_in), .rdata_in(rdata), .addr_out(reg_addr), .wr_out(reg_wr),
        .wdata_out(reg_wdata), .rd_out(reg_rd));
    pfe_event_reset dut_u (.clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr),
        .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
        .power_ok_gating_select_in(gate_sel), .conv0_monitor_enable_in(mon0), .conv1_monitor_enable_in(mon1),
        .conv0_valid_in(val0), .conv1_valid_in(val1), .conv_event_reg_in(conv_evt), .ext_clock_present_in(ext_clk),
        .thermal_shutdown_live_in(tsd), .thermal_warning_live_in(warn), .input_overvoltage_live_in(ovp),
        .current_meas_ready_in(meas), .conv0_enable_req_in(en0), .conv1_enable_req_in(en1),
        .general_output_a_req_in(ga), .general_output_b_req_in(gb), .power_ok_output_out(pok),
        .conv0_enable_out(cen0), .conv1_enable_out(cen1), .general_output_a_out(goa),
        .general_output_b_out(gob), .otp_reload_out(otp), .serial_reset_out(srst));

    task automatic close_out;
        if (err_total == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        clock_in = 1'b0;
        forever #12.5 clock_in = ~clock_in;
    end
    // the whole sequence needs under a hundred cycles
    initial begin
        #50us;
        err_total++;
        close_out();
    end

    initial begin
        {err_total, tests_run} = '0;
        rst_n_in = 1'b0;
        {gate_sel, mon0, mon1, val0, val1} = 5'h1F;
        {ext_clk, tsd, warn, ovp, meas, en0, en1, ga, gb} = 9'h000;
        conv_evt = 8'h00;
        repeat (2) @(negedge clock_in);
        `CHK({pok, cen0, cen1, goa, gob, otp, srst, rdata}, 15'h0000)
        rst_n_in = 1'b1;
        host_u.rd_reg(ADDR_FAULT_LATCH, rd_val);
        `CHK(rd_val, {6'h00, FAULT_RESET})
        foreach (rows[i]) begin
            @(negedge clock_in);
            {ext_clk, warn, ovp, meas} = rows[i].stim[4:1];
            conv_evt = rows[i].stim[0] ? 8'h40 : 8'h00;
            host_u.wr_reg(ADDR_TOP_EVENTS, 8'h00);
            host_u.rd_reg(ADDR_TOP_EVENTS, rd_val);
            `CHK(rd_val, rows[i].flags)
            {ext_clk, warn, ovp, meas} = 4'h0;
            conv_evt = 8'h00;
            host_u.wr_reg(ADDR_TOP_EVENTS, TOP_W1C_MASK);
            host_u.rd_reg(ADDR_TOP_EVENTS, rd_val);
            `CHK(rd_val, TOP_RESET)
        end
        `CHK(pok, 1'b1)
        // converter 0 drops while unmonitored, converter 1 while monitored
        mon0 = 1'b0;
        {val0, val1} = 2'h0;
        repeat (2) @(negedge clock_in);
        `CHK(pok, 1'b0)
        host_u.rd_reg(ADDR_FAULT_LATCH, rd_val);
        `CHK(rd_val, 8'h02)
        host_u.rd_reg(ADDR_TOP_EVENTS, rd_val);
        `CHK(rd_val, 8'h80)
        host_u.wr_reg(ADDR_FAULT_LATCH, 8'h03);
        host_u.rd_reg(ADDR_FAULT_LATCH, rd_val);
        `CHK(rd_val, 8'h02)
        {val0, val1} = 2'h3;
        repeat (2) @(negedge clock_in);
        `CHK(pok, 1'b0)
        host_u.wr_reg(ADDR_FAULT_LATCH, 8'h03);
        host_u.wr_reg(ADDR_TOP_EVENTS, 8'h80);
        host_u.rd_reg(ADDR_FAULT_LATCH, rd_val);
        `CHK({rd_val, pok}, 9'h001)
        {en0, en1, ga, gb} = 4'hF;
        repeat (2) @(negedge clock_in);
        `CHK({cen0, cen1, goa, gob}, 4'hF)
        tsd = 1'b1;
        repeat (2) @(negedge clock_in);
        `CHK({cen0, cen1, goa, gob}, 4'h0)
        en0 = 1'b0;
        @(negedge clock_in);
        en0 = 1'b1;
        host_u.rd_reg(ADDR_TOP_EVENTS, rd_val);
        `CHK({rd_val, cen0}, 9'h010)
        host_u.rd_reg(ADDR_LIVE_STATUS, rd_val);
        `CHK(rd_val, 8'h98)
        tsd = 1'b0;
        host_u.wr_reg(ADDR_TOP_EVENTS, 8'h08);
        en0 = 1'b0;
        @(negedge clock_in);
        en0 = 1'b1;
        repeat (2) @(negedge clock_in);
        `CHK(cen0, 1'b1)
        {mon0, val0} = 2'h2;
        repeat (2) @(negedge clock_in);
        host_u.rd_reg(ADDR_FAULT_LATCH, rd_val);
        `CHK(rd_val, 8'h01)
        host_u.wr_reg(ADDR_FAULT_LATCH, 8'h01);
        host_u.rd_reg(ADDR_FAULT_LATCH, rd_val);
        `CHK(rd_val, 8'h01)
        warn = 1'b1;
        host_u.wr_reg(ADDR_SOFT_RESET, 8'h01);
        `CHK({otp, srst}, 2'h3)
        host_u.rd_reg(ADDR_TOP_EVENTS, rd_val);
        `CHK(rd_val, TOP_RESET)
        host_u.rd_reg(ADDR_SOFT_RESET, rd_val);
        `CHK(rd_val, 8'h00)
        close_out();
    end
endmodule // pfe_event_reset_tb
`default_nettype wire
